// [logic/mdc_div_step.sv]
// two restoring-division steps per cycle on magnitudes
`timescale 1ns/1ps
module mdc_div_step (
    // partial state in
    input  wire logic [31:0] rem_in,
    input  wire logic [31:0] quo_in,
    input  wire logic [31:0] dsr,
    // partial state out
    output logic      [31:0] rem_out,
    output logic      [31:0] quo_out
);
    function automatic logic [64:0] step(input logic [31:0] r, input logic [31:0] q,
                                         input logic [31:0] d);
        logic [32:0] t;
        logic [32:0] s;
        t = {r, q[31]};
        s = t - {1'b0, d};
        if (!s[32])
            step = {1'b0, s[31:0], q[30:0], 1'b1};
        else
            step = {1'b0, t[31:0], q[30:0], 1'b0};
    endfunction : step
    wire logic [64:0] s1 = step(rem_in, quo_in, dsr);
    wire logic [64:0] s2 = step(s1[63:32], s1[31:0], dsr);
    assign rem_out = s2[63:32];
    assign quo_out = s2[31:0];
endmodule : mdc_div_step

// [logic/mdc_mul16.sv]
// single-cycle 16x16 multiplier, signed or unsigned
`timescale 1ns/1ps
module mdc_mul16 (
    // operands
    input  wire logic [15:0] a,
    input  wire logic [15:0] b,
    input  wire logic        is_signed,
    // product
    output logic      [31:0] p
);
    wire logic [16:0] a_x = {is_signed & a[15], a};
    wire logic [16:0] b_x = {is_signed & b[15], b};
    wire logic signed [33:0] prod = $signed(a_x) * $signed(b_x);
    assign p = prod[31:0];
endmodule : mdc_mul16

// [logic/mdc_pkg.sv]
// shared constants for the multiply/divide coprocessor
package mdc_pkg;
    localparam int          MODE_W       = 7;
    localparam int          OP_W         = 4;
    localparam int          OUT_LSB      = 4;
    localparam logic [3:0]  OP_INIT2     = 4'h2;
    localparam logic [3:0]  OP_READ      = 4'h3;
    localparam logic [3:0]  OP_MULU      = 4'h4;
    localparam logic [3:0]  OP_MULS      = 4'h5;
    localparam logic [3:0]  OP_DIVU      = 4'h8;
    localparam logic [3:0]  OP_DIVS      = 4'h9;
    localparam logic [2:0]  OUT_R0_LO    = 3'h0;
    localparam logic [2:0]  OUT_R0_HI    = 3'h1;
    localparam logic [2:0]  OUT_R1_LO    = 3'h2;
    localparam logic [2:0]  OUT_R1_HI    = 3'h3;
    localparam logic [6:0]  MODE_RST     = 7'h00;
    localparam logic [31:0] RES_RST      = 32'h0000_0000;
    localparam logic [3:0]  FLAGS_RST    = 4'h0;
    localparam int          DIV_STEPS    = 32;
    localparam int          DIV_RADIX_B  = 2;
    localparam int          DIV_MIN_CYC  = 17;
    localparam int          DIV_MAX_CYC  = 20;
    localparam int          DIV_ITER     = DIV_STEPS / DIV_RADIX_B;
    localparam logic [4:0]  DIV_ITER_CNT = 5'(DIV_ITER);
endpackage : mdc_pkg

// [logic/mdc_top.sv]
// multiply/divide coprocessor datapath facing the host core
// How it works
// - product of two 16-bit operands fills result zero
// - 0x04 unsigned, 0x05 signed multiply, low half
// - one transfer carries operands, starts, returns result
// - multiply returns flags all cleared
// - 0x14/0x15 return product high half
// - result zero holds until overwritten
// - 0x13 reads result zero high half
// - immediate form uses immediate as second operand
// - 32/32 division gives quotient and remainder
// - mode 0x02 load fills result zero halves
// - 0x08 unsigned, 0x09 signed divide, low half
// - divisor transfer starts divide, quotient/remainder stored
// - divisor transfer returns quotient low and flags
// - 0x23 reads remainder low half
// - 0x33 reads remainder high half
// - 7-bit mode: output select and operation
// - divide done in 17..20 cycles, no checks
// - multiply finishes in one cycle
`timescale 1ns/1ps
module mdc_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // mode write
    input  wire logic        mode_wr,
    input  wire logic [6:0]  mode_in,
    // operand transfer
    input  wire logic        xfer_req,
    input  wire logic        xfer_load,
    input  wire logic        xfer_imm,
    input  wire logic [31:0] opnd_first,
    input  wire logic [31:0] opnd_second,
    input  wire logic [15:0] short_immediate,
    // answer
    output logic             xfer_busy,
    output logic             xfer_done,
    output logic      [15:0] xfer_data,
    output logic      [3:0]  carry_overflow_zero_negative_flags,
    // state
    output logic      [6:0]  mode_word,
    output logic      [31:0] result_reg_zero,
    output logic      [31:0] result_reg_one
);
    typedef enum logic [1:0] {
        MDC_IDLE = 2'b01,
        MDC_DIV  = 2'b10
    } mdc_state_t;

    mdc_state_t  state_r, state_nxt;
    logic [6:0]  mode_r;
    logic [31:0] result_reg_zero_r, result_reg_one_r;
    logic [31:0] rem_r, quo_r, dsr_r;
    logic        neg_q_r, neg_r_r;
    logic [4:0]  cnt_r;
    logic        busy_r, done_r;
    logic [15:0] data_r;
    logic [3:0]  flg_r;

    function automatic logic [31:0] mag(input logic [31:0] v, input logic sgn);
        mag = (sgn && v[31]) ? 32'(-v) : v;
    endfunction : mag

    function automatic logic [15:0] pick(input logic [2:0] sel, input logic [31:0] r0,
                                         input logic [31:0] r1);
        case (sel)
            mdc_pkg::OUT_R0_HI: pick = r0[31:16];
            mdc_pkg::OUT_R1_LO: pick = r1[15:0];
            mdc_pkg::OUT_R1_HI: pick = r1[31:16];
            default:            pick = r0[15:0];
        endcase
    endfunction : pick

    // mode field decode
    wire logic [3:0]  op_sel   = mode_r[mdc_pkg::OP_W-1:0];
    wire logic [2:0]  out_sel  = mode_r[mdc_pkg::MODE_W-1:mdc_pkg::OUT_LSB];
    wire logic        idle     = (state_r == MDC_IDLE);
    wire logic        take     = xfer_req && idle;
    wire logic        is_mul   = (op_sel == mdc_pkg::OP_MULU) || (op_sel == mdc_pkg::OP_MULS);
    wire logic        is_div   = (op_sel == mdc_pkg::OP_DIVU) || (op_sel == mdc_pkg::OP_DIVS);
    wire logic        sgn_mul  = (op_sel == mdc_pkg::OP_MULS);
    wire logic        sgn_div  = (op_sel == mdc_pkg::OP_DIVS);
    wire logic        do_init2 = take && xfer_load && (op_sel == mdc_pkg::OP_INIT2);
    wire logic        do_mul   = take && !xfer_load && is_mul;
    wire logic        do_div   = take && !xfer_load && is_div;
    wire logic        do_read  = take && !do_init2 && !do_mul && !do_div;
    // second operand from register or short immediate
    wire logic [31:0] opnd2    = xfer_imm ? {16'h0000, short_immediate} : opnd_second;
    wire logic [31:0] product;

    mdc_mul16 u_mul (
        .a         (opnd_first[15:0]),
        .b         (opnd2[15:0]),
        .is_signed (sgn_mul),
        .p         (product)
    );

    wire logic [31:0] step_rem, step_quo;
    mdc_div_step u_div (
        .rem_in  (rem_r),
        .quo_in  (quo_r),
        .dsr     (dsr_r),
        .rem_out (step_rem),
        .quo_out (step_quo)
    );

    wire logic        div_last  = (state_r == MDC_DIV) && (cnt_r == 5'h01);
    wire logic [31:0] quo_fix   = neg_q_r ? 32'(-step_quo) : step_quo;
    wire logic [31:0] rem_fix   = neg_r_r ? 32'(-step_rem) : step_rem;
    wire logic [31:0] result_reg_zero_mul  = product;
    wire logic [31:0] result_reg_zero_ini  = {opnd_first[15:0], opnd2[15:0]};
    wire logic [31:0] result_reg_zero_next = do_mul   ? result_reg_zero_mul :
                                  do_init2 ? result_reg_zero_ini :
                                  div_last ? quo_fix  : result_reg_zero_r;
    wire logic [31:0] result_reg_one_next = div_last ? rem_fix : result_reg_one_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            MDC_IDLE: if (do_div) state_nxt = MDC_DIV;
            MDC_DIV:  if (div_last) state_nxt = MDC_IDLE;
            default:  state_nxt = MDC_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= MDC_IDLE;
            mode_r  <= mdc_pkg::MODE_RST;
            result_reg_zero_r  <= mdc_pkg::RES_RST;
            result_reg_one_r  <= mdc_pkg::RES_RST;
        end
        else
        begin
            state_r <= state_nxt;
            if (mode_wr && idle)
                mode_r <= mode_in;
            result_reg_zero_r <= result_reg_zero_next;
            result_reg_one_r <= result_reg_one_next;
        end
    end

    // divider working registers, dividend taken from result zero
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rem_r   <= mdc_pkg::RES_RST;
            quo_r   <= mdc_pkg::RES_RST;
            dsr_r   <= mdc_pkg::RES_RST;
            neg_q_r <= 1'b0;
            neg_r_r <= 1'b0;
            cnt_r   <= 5'h00;
        end
        else if (do_div)
        begin
            rem_r   <= mdc_pkg::RES_RST;
            quo_r   <= mag(result_reg_zero_r, sgn_div);
            dsr_r   <= mag(opnd2, sgn_div);
            neg_q_r <= sgn_div && (result_reg_zero_r[31] ^ opnd2[31]);
            neg_r_r <= sgn_div && result_reg_zero_r[31];
            cnt_r   <= mdc_pkg::DIV_ITER_CNT;
        end
        else if (state_r == MDC_DIV)
        begin
            rem_r <= step_rem;
            quo_r <= step_quo;
            cnt_r <= 5'(cnt_r - 5'h01);
        end
    end

    // answer path: data, flags, busy and done
    wire logic [15:0] mul_out  = out_sel[0] ? product[31:16] : product[15:0];
    wire logic [15:0] data_nxt = do_mul   ? mul_out       :
                                 div_last ? quo_fix[15:0] :
                                 pick(out_sel, result_reg_zero_next, result_reg_one_next);
    wire logic        done_nxt = do_mul || do_read || do_init2 || div_last;
    wire logic        busy_nxt = do_div || ((state_r == MDC_DIV) && !div_last);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            data_r <= 16'h0000;
            flg_r  <= mdc_pkg::FLAGS_RST;
        end
        else
        begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            if (done_nxt)
                data_r <= data_nxt;
            if (done_nxt)
                flg_r <= mdc_pkg::FLAGS_RST;
        end
    end

    assign xfer_busy = busy_r;
    assign xfer_done = done_r;
    assign xfer_data = data_r;
    assign carry_overflow_zero_negative_flags = flg_r;
    assign mode_word       = mode_r;
    assign result_reg_zero = result_reg_zero_r;
    assign result_reg_one  = result_reg_one_r;

    // checks
    AST_MUL_ONE: assert property (@(posedge clk) disable iff (!rstn)
        do_mul |=> xfer_done && result_reg_zero == $past(product))
        else $error("multiply not done in one cycle");
    AST_MUL_LO: assert property (@(posedge clk) disable iff (!rstn)
        do_mul && !out_sel[0] |=> xfer_data == result_reg_zero[15:0])
        else $error("multiply low half wrong");
    AST_MUL_HI: assert property (@(posedge clk) disable iff (!rstn)
        do_mul && out_sel[0] |=> xfer_data == result_reg_zero[31:16])
        else $error("multiply high half wrong");
    AST_FLAGS: assert property (@(posedge clk) disable iff (!rstn)
        do_mul |=> carry_overflow_zero_negative_flags == 4'h0)
        else $error("flags not cleared");
    AST_INIT2: assert property (@(posedge clk) disable iff (!rstn)
        do_init2 |=> result_reg_zero == {$past(opnd_first[15:0]), $past(opnd2[15:0])})
        else $error("initialize load wrong");
    AST_DIV_TIME: assert property (@(posedge clk) disable iff (!rstn)
        do_div |=> xfer_busy ##[16:19] xfer_done)
        else $error("division time out of range");
    AST_BUSY: assert property (@(posedge clk) disable iff (!rstn)
        xfer_busy |-> !xfer_done)
        else $error("done during busy");
    AST_DIV_OUT: assert property (@(posedge clk) disable iff (!rstn)
        div_last |=> xfer_data == result_reg_zero[15:0])
        else $error("quotient low half not returned");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        idle && !xfer_req |=> $stable(result_reg_zero))
        else $error("result zero changed without operation");
    AST_READ: assert property (@(posedge clk) disable iff (!rstn)
        do_read && out_sel == mdc_pkg::OUT_R1_HI |=> xfer_data == result_reg_one[31:16])
        else $error("remainder high read wrong");

    // read paths
    AST_READ_R0HI: assert property (@(posedge clk) disable iff (!rstn)
        do_read && out_sel == mdc_pkg::OUT_R0_HI |=> xfer_data == result_reg_zero[31:16])
        else $error("result zero high read wrong");

    AST_READ_R1LO: assert property (@(posedge clk) disable iff (!rstn)
        do_read && out_sel == mdc_pkg::OUT_R1_LO |=> xfer_data == result_reg_one[15:0])
        else $error("remainder low read wrong");

    AST_READ_KEEP: assert property (@(posedge clk) disable iff (!rstn)
        do_read |=> $stable(result_reg_zero) && $stable(result_reg_one))
        else $error("read changed a result");

    AST_READ_DONE: assert property (@(posedge clk) disable iff (!rstn)
        do_read |=> xfer_done && !xfer_busy)
        else $error("read not answered in one cycle");

    // multiply products
    AST_MUL_UNS: assert property (@(posedge clk) disable iff (!rstn)
        do_mul && !sgn_mul |=>
        result_reg_zero == $past(opnd_first[15:0]) * $past(opnd2[15:0]))
        else $error("unsigned product wrong");

    AST_MUL_SGN: assert property (@(posedge clk) disable iff (!rstn)
        do_mul && sgn_mul |=> $signed(result_reg_zero) ==
        $signed($past(opnd_first[15:0])) * $signed($past(opnd2[15:0])))
        else $error("signed product wrong");

    AST_MUL_IMM: assert property (@(posedge clk) disable iff (!rstn)
        do_mul && xfer_imm && !sgn_mul |=>
        result_reg_zero == $past(opnd_first[15:0]) * $past(short_immediate))
        else $error("immediate operand not used");

    // initialize load
    AST_INIT_DONE: assert property (@(posedge clk) disable iff (!rstn)
        do_init2 |=> xfer_done && !xfer_busy)
        else $error("initialize load not answered");

    // division
    AST_DIV_DVD: assert property (@(posedge clk) disable iff (!rstn)
        do_div |=> quo_r == mag($past(result_reg_zero), $past(sgn_div)))
        else $error("dividend not taken from result zero");

    AST_DIV_START: assert property (@(posedge clk) disable iff (!rstn)
        do_div |=> xfer_busy && !xfer_done)
        else $error("division did not start");

    AST_DIV_RUN: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == MDC_DIV) && !div_last |=> xfer_busy)
        else $error("busy dropped during division");

    AST_DIV_END: assert property (@(posedge clk) disable iff (!rstn)
        div_last |=> !xfer_busy && xfer_done)
        else $error("division end handshake wrong");

    AST_DIV_RESULT_REG_ZERO: assert property (@(posedge clk) disable iff (!rstn)
        div_last |=> result_reg_zero == $past(quo_fix))
        else $error("quotient not stored");

    AST_DIV_RESULT_REG_ONE: assert property (@(posedge clk) disable iff (!rstn)
        div_last |=> result_reg_one == $past(rem_fix))
        else $error("remainder not stored");

    AST_DIV_FLAGS: assert property (@(posedge clk) disable iff (!rstn)
        div_last |=> carry_overflow_zero_negative_flags == 4'h0)
        else $error("division flags not returned");

    // mode word and holding
    AST_MODE_WR: assert property (@(posedge clk) disable iff (!rstn)
        mode_wr && idle |=> mode_word == $past(mode_in))
        else $error("mode word not written");

    AST_MODE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !idle |=> mode_word == $past(mode_word))
        else $error("mode word changed while busy");

    AST_RESULT_REG_ONE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !div_last |=> $stable(result_reg_one))
        else $error("result one changed without division");

    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!rstn)
        idle && !xfer_req |=> !xfer_busy && !xfer_done)
        else $error("answer without request");
endmodule : mdc_top

// [tb/mdc_host_model.sv]
// host core model issuing mode writes and operand transfers
`timescale 1ns/1ps
module mdc_host_model (
    // clock
    input  wire logic        clk,
    // answer
    input  wire logic        xfer_busy,
    input  wire logic        xfer_done,
    input  wire logic [15:0] xfer_data,
    input  wire logic [3:0]  flags,
    // request
    output logic             mode_wr,
    output logic      [6:0]  mode_in,
    output logic             xfer_req,
    output logic             xfer_load,
    output logic             xfer_imm,
    output logic      [31:0] opnd_first,
    output logic      [31:0] opnd_second,
    output logic      [15:0] short_immediate
);
    initial
    begin
        {mode_wr, mode_in, xfer_req, xfer_load, xfer_imm} = 11'h000;
        {opnd_first, opnd_second, short_immediate} = 80'h0;
    end

    task automatic set_mode(input logic [6:0] m);
        @(negedge clk);
        mode_wr <= 1'b1;
        mode_in <= m;
        @(negedge clk);
        mode_wr <= 1'b0;
        mode_in <= ~m;
    endtask : set_mode

    // both operands in one transfer, released lines show the inverse
    task automatic xfer(input logic ld, input logic im, input logic [31:0] a,
                        input logic [31:0] b, input logic [15:0] si,
                        output logic [15:0] d, output logic [3:0] f, output int n);
        while (xfer_busy === 1'b1)
            @(negedge clk);
        @(negedge clk);
        {xfer_req, xfer_load, xfer_imm} <= {1'b1, ld, im};
        {opnd_first, opnd_second, short_immediate} <= {a, b, si};
        n = 0;
        do
        begin
            @(negedge clk);
            xfer_req <= 1'b0;
            {opnd_first, opnd_second, short_immediate} <= ~{a, b, si};
            n++;
        end
        while (xfer_done !== 1'b1 && n < 40);
        d = xfer_data;
        f = flags;
    endtask : xfer
endmodule : mdc_host_model

// [tb/testbench.sv]
// self-checking bench for the multiply/divide coprocessor
`timescale 1ns/1ps
module testbench;
    logic        clk, rstn, mode_wr, xfer_req, xfer_load, xfer_imm, xfer_busy, xfer_done;
    logic [6:0]  mode_in, mode_word;
    logic [31:0] opnd_first, opnd_second, result_reg_zero, result_reg_one;
    logic [15:0] short_immediate, xfer_data;
    logic [3:0]  flags;
    int          error_cnt = 0;
    int          compares  = 0;
    int          cycles    = 0;

    mdc_top u_dut (.clk(clk), .rstn(rstn), .mode_wr(mode_wr), .mode_in(mode_in),
        .xfer_req(xfer_req), .xfer_load(xfer_load), .xfer_imm(xfer_imm),
        .opnd_first(opnd_first), .opnd_second(opnd_second),
        .short_immediate(short_immediate), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
        .xfer_data(xfer_data), .carry_overflow_zero_negative_flags(flags),
        .mode_word(mode_word), .result_reg_zero(result_reg_zero),
        .result_reg_one(result_reg_one));

    mdc_host_model u_host (.clk(clk), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
        .xfer_data(xfer_data), .flags(flags), .mode_wr(mode_wr), .mode_in(mode_in),
        .xfer_req(xfer_req), .xfer_load(xfer_load), .xfer_imm(xfer_imm),
        .opnd_first(opnd_first), .opnd_second(opnd_second),
        .short_immediate(short_immediate));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // whole run needs about 120 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng

    task automatic rd(input logic [6:0] m, input logic [15:0] exp);
        logic [15:0] d;
        logic [3:0]  f;
        int          n;
        u_host.set_mode(m);
        u_host.xfer(1'b0, 1'b0, 32'h0, 32'h0, 16'h0, d, f, n);
        chk_val("read half", {16'h0, exp}, {16'h0, d});
        chk_rng("read latency", 1, 1, n);
    endtask : rd

    task automatic t_reset();
        chk_val("reset outputs", 32'h0, {3'h0, xfer_busy, xfer_done, xfer_data, flags, mode_word});
        chk_val("reset results", 32'h0, result_reg_zero | result_reg_one);
    endtask : t_reset

    task automatic t_mul();
        logic [6:0]  modes [4] = '{7'h04, 7'h05, 7'h14, 7'h15};
        logic [31:0] p;
        logic [15:0] d;
        logic [3:0]  f;
        int          n;
        foreach (modes[i])
        begin
            p = modes[i][0] ? 32'hfffe_8000 : 32'h0001_8000;
            u_host.set_mode(modes[i]);
            u_host.xfer(1'b0, 1'b0, 32'ha5a5_8000, 32'h5a5a_0003, 16'h1111, d, f, n);
            chk_val("product", p, result_reg_zero);
            chk_val("product half", {16'h0, modes[i][4] ? p[31:16] : p[15:0]}, {16'h0, d});
            chk_val("mul flags", 32'h0, {28'h0, f});
            chk_rng("mul latency", 1, 1, n);
        end
        rd(7'h13, p[31:16]);
        rd(7'h03, p[15:0]);
        chk_val("product held", p, result_reg_zero);
        u_host.set_mode(7'h05);
        u_host.xfer(1'b0, 1'b1, 32'h0000_fff0, 32'h1234_5678, 16'h0007, d, f, n);
        chk_val("immediate product", 32'hffff_ff90, result_reg_zero);
    endtask : t_mul

    task automatic t_div(input logic sgn, input logic [31:0] dvd, input logic [31:0] dsr);
        logic [31:0] q, r;
        logic [15:0] d;
        logic [3:0]  f;
        int          n;
        // concatenation keeps each operand self-determined, so signed stays signed
        if (sgn)
            {q, r} = {$signed(dvd) / $signed(dsr), $signed(dvd) % $signed(dsr)};
        else
            {q, r} = {dvd / dsr, dvd % dsr};
        u_host.set_mode(7'h02);
        u_host.xfer(1'b1, 1'b0, {16'h0, dvd[31:16]}, {16'h0, dvd[15:0]}, 16'h0, d, f, n);
        chk_val("dividend", dvd, result_reg_zero);
        u_host.set_mode({6'h04, sgn});
        fork
            u_host.xfer(1'b0, 1'b0, 32'h0, dsr, 16'h0, d, f, n);
            begin
                repeat (4) @(negedge clk);
                chk_val("busy", 32'h1, {31'h0, xfer_busy});
                u_host.set_mode(7'h33);
            end
        join
        chk_rng("divide latency", 17, 20, n);
        chk_val("mode kept", {26'h04, sgn}, {25'h0, mode_word});
        chk_val("quotient", q, result_reg_zero);
        chk_val("remainder", r, result_reg_one);
        chk_val("div answer", {16'h0, q[15:0]}, {12'h0, f, d});
        rd(7'h13, q[31:16]);
        rd(7'h23, r[15:0]);
        rd(7'h33, r[31:16]);
    endtask : t_div

    initial
    begin
        rstn = 1'b0;
        repeat (20) @(negedge clk);
        t_reset();
        rstn <= 1'b1;
        t_mul();
        t_div(1'b0, 32'h1234_5678, 32'h0000_0100);
        t_div(1'b1, 32'hffff_ff9c, 32'h0000_0007);
        close_out();
    end
endmodule : testbench
